// file: design/rot_pkg.sv
// constants, field positions and types for the output pin and trim block
// assumes a 100 MHz core clock and a 32.768 kHz oscillator tick enable
package rot_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h07;
    localparam logic [7:0] ADDR_OSC_TRIM = 8'h08;
    localparam logic [7:0] ADDR_ALARM0_WEEKDAY_VALUE = 8'h0d;
    localparam logic [7:0] ADDR_ALARM1_WEEKDAY_VALUE = 8'h14;

    // reset values
    localparam logic [7:0] RST_CONTROL = 8'h80;
    localparam logic [7:0] RST_OSC_TRIM = 8'h00;
    localparam logic [7:0] RST_ALARM_WEEKDAY_VALUE = 8'h00;

    // rtc_control fields
    localparam int CTL_PIN_LEVEL = 7;
    localparam int CTL_SQW_EN = 6;
    localparam int CTL_ALM1_EN = 5;
    localparam int CTL_ALM0_EN = 4;
    localparam int CTL_EXT_CLK = 3;
    localparam int CTL_COARSE = 2;
    localparam int CTL_RATE_HI = 1;
    localparam int CTL_RATE_LO = 0;

    // oscillator_trim fields
    localparam int TRIM_SIGN = 7;
    localparam int TRIM_MAG_HI = 6;
    localparam int TRIM_MAG_W = 7;

    // alarm weekday fields
    localparam int ALM_POL = 7;
    localparam int ALM_MASK_HI = 6;
    localparam int ALM_MASK_LO = 4;
    localparam int ALM_FLAG = 3;
    localparam int ALM_WEEKDAY_VALUE_HI = 2;

    // oscillator timing in oscillator ticks
    localparam int OSC_HZ = 32768;
    localparam int SEC_PER_MIN = 60;
    localparam int MINUTE_TICKS = OSC_HZ * SEC_PER_MIN;
    localparam int COARSE_HZ = 128;
    localparam int COARSE_TICKS = OSC_HZ / COARSE_HZ;

    // square wave prescaler taps
    localparam int PS_W = 15;
    localparam int PS_TAP_DIV4 = 1;
    localparam int PS_TAP_DIV8 = 2;
    localparam int PS_TAP_DIV32768 = 14;
    localparam int PS_TAP_COARSE = 8;

    // square wave rate select codes
    typedef enum logic [1:0] {
        RATE_1_1,
        RATE_1_4,
        RATE_1_8,
        RATE_1_32768
    } rot_rate_type;

    // trim unit states
    typedef enum logic [1:0] {
        TRIM_IDLE,
        TRIM_ADD,
        TRIM_SUB
    } rot_trim_state_type;

endpackage : rot_pkg

// file: design/rot_trim.sv
// digital trim unit: inserts or swallows oscillator ticks each period
// assumes osc_tick is a one-cycle enable, never two cycles back to back
`timescale 1ns/1ps
module rot_trim #(
    parameter int unsigned MINUTE_TICKS = rot_pkg::MINUTE_TICKS
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // oscillator and trim setting
    input wire logic osc_tick,
    input wire logic coarse_trim_mode,
    input wire logic trim_sign,
    input wire logic [rot_pkg::TRIM_MAG_W-1:0] trim_magnitude,
    // trimmed tick enable
    output logic trim_tick
);

    localparam int CNT_W = $clog2(MINUTE_TICKS);

    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] period_last;
    logic boundary;
    logic [7:0] pending;
    rot_pkg::rot_trim_state_type state;

    // period end: once a minute, or at 128 Hz in coarse mode
    assign period_last = coarse_trim_mode
        ? CNT_W'(rot_pkg::COARSE_TICKS - 1)
        : CNT_W'(MINUTE_TICKS - 1);
    assign boundary = osc_tick && (period_cnt >= period_last);

    // raw oscillator tick counter; runs on backup power too
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            period_cnt <= '0;
        else if (boundary)
            period_cnt <= '0;
        else if (osc_tick)
            period_cnt <= period_cnt + CNT_W'(1);
    end

    // adjustment sequencer: one contiguous burst per period
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= rot_pkg::TRIM_IDLE;
            pending <= 8'h00;
        end
        else
        begin
            unique case (state)
                rot_pkg::TRIM_IDLE:
                    // zero magnitude never starts a burst
                    if (boundary && trim_magnitude != '0)
                    begin
                        pending <= {trim_magnitude, 1'b0};
                        state <= trim_sign ? rot_pkg::TRIM_ADD
                                           : rot_pkg::TRIM_SUB;
                    end
                rot_pkg::TRIM_ADD:
                    // extra ticks fill cycles between real ones
                    if (!osc_tick)
                    begin
                        pending <= pending - 8'h01;
                        if (pending == 8'h01)
                            state <= rot_pkg::TRIM_IDLE;
                    end
                rot_pkg::TRIM_SUB:
                    // consecutive real ticks are swallowed
                    if (osc_tick)
                    begin
                        pending <= pending - 8'h01;
                        if (pending == 8'h01)
                            state <= rot_pkg::TRIM_IDLE;
                    end
                default:
                    state <= rot_pkg::TRIM_IDLE;
            endcase
        end
    end

    // trimmed tick output
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            trim_tick <= 1'b0;
        else
        begin
            unique case (state)
                rot_pkg::TRIM_ADD: trim_tick <= 1'b1;
                rot_pkg::TRIM_SUB: trim_tick <= 1'b0;
                default: trim_tick <= osc_tick;
            endcase
        end
    end

endmodule : rot_trim

// file: design/rot_top.sv
// multi-function output pin and digital trim of a real-time clock
// assumes the serial slave presents byte reads and writes on core_clk,
// osc_tick is a one-cycle enable per oscillator period and alarm hits
// arrive as one-cycle pulses from the alarm comparators
`timescale 1ns/1ps
module rot_top #(
    parameter int unsigned MINUTE_TICKS = rot_pkg::MINUTE_TICKS
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register access from the serial slave
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // oscillator
    input wire logic osc_tick,
    input wire logic osc_level,
    // alarm comparators and supply state
    input wire logic alarm0_hit,
    input wire logic alarm1_hit,
    input wire logic on_backup,
    // multi-function pin, open drain
    input wire logic multi_function_pin_i,
    output logic multi_function_pin_o,
    output logic multi_function_pin_oe,
    // status to the rest of the clock
    output logic trim_tick,
    output logic external_clock_input,
    output logic alarm0_flag,
    output logic alarm1_flag
);

    // control register fields
    logic pin_level;
    logic square_wave_enable;
    logic alarm1_enable;
    logic alarm0_enable;
    logic ext_clk_bit;
    logic coarse_trim_mode;
    logic [1:0] square_wave_rate_select;

    // trim register fields
    logic trim_sign;
    logic [rot_pkg::TRIM_MAG_W-1:0] trim_magnitude;

    // alarm weekday fields
    logic alarm_polarity;
    logic [2:0] alarm0_match_mask;
    logic [2:0] alarm1_match_mask;
    logic [2:0] alarm0_weekday_value;
    logic [2:0] alarm1_weekday_value;

    // internal nets
    logic wr_en;
    logic trim_tick_int;
    logic [rot_pkg::PS_W-1:0] prescale;
    logic sqw_level;
    logic alarm_level;
    logic next_pin_level;
    logic next_pin_drive;
    logic [7:0] next_rdata;

    // register writes; the serial slave is down on backup power
    assign wr_en = reg_wr && !on_backup;

    // rtc_control register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_level <= rot_pkg::RST_CONTROL[rot_pkg::CTL_PIN_LEVEL];
            square_wave_enable <= rot_pkg::RST_CONTROL[rot_pkg::CTL_SQW_EN];
            alarm1_enable <= rot_pkg::RST_CONTROL[rot_pkg::CTL_ALM1_EN];
            alarm0_enable <= rot_pkg::RST_CONTROL[rot_pkg::CTL_ALM0_EN];
            ext_clk_bit <= rot_pkg::RST_CONTROL[rot_pkg::CTL_EXT_CLK];
            coarse_trim_mode <= rot_pkg::RST_CONTROL[rot_pkg::CTL_COARSE];
            square_wave_rate_select <=
                rot_pkg::RST_CONTROL[rot_pkg::CTL_RATE_HI:rot_pkg::CTL_RATE_LO];
        end
        else if (wr_en && reg_addr == rot_pkg::ADDR_CONTROL)
        begin
            pin_level <= reg_wdata[rot_pkg::CTL_PIN_LEVEL];
            square_wave_enable <= reg_wdata[rot_pkg::CTL_SQW_EN];
            alarm1_enable <= reg_wdata[rot_pkg::CTL_ALM1_EN];
            alarm0_enable <= reg_wdata[rot_pkg::CTL_ALM0_EN];
            ext_clk_bit <= reg_wdata[rot_pkg::CTL_EXT_CLK];
            coarse_trim_mode <= reg_wdata[rot_pkg::CTL_COARSE];
            square_wave_rate_select <=
                reg_wdata[rot_pkg::CTL_RATE_HI:rot_pkg::CTL_RATE_LO];
        end
    end

    // oscillator_trim register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trim_sign <= rot_pkg::RST_OSC_TRIM[rot_pkg::TRIM_SIGN];
            trim_magnitude <= rot_pkg::RST_OSC_TRIM[rot_pkg::TRIM_MAG_HI:0];
        end
        else if (wr_en && reg_addr == rot_pkg::ADDR_OSC_TRIM)
        begin
            trim_sign <= reg_wdata[rot_pkg::TRIM_SIGN];
            trim_magnitude <= reg_wdata[rot_pkg::TRIM_MAG_HI:0];
        end
    end

    // alarm weekday config fields; polarity lives in alarm 0 only
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            alarm_polarity <= rot_pkg::RST_ALARM_WEEKDAY_VALUE[rot_pkg::ALM_POL];
            alarm0_match_mask <= rot_pkg::RST_ALARM_WEEKDAY_VALUE[
                rot_pkg::ALM_MASK_HI:rot_pkg::ALM_MASK_LO];
            alarm1_match_mask <= rot_pkg::RST_ALARM_WEEKDAY_VALUE[
                rot_pkg::ALM_MASK_HI:rot_pkg::ALM_MASK_LO];
            alarm0_weekday_value <=
                rot_pkg::RST_ALARM_WEEKDAY_VALUE[rot_pkg::ALM_WEEKDAY_VALUE_HI:0];
            alarm1_weekday_value <=
                rot_pkg::RST_ALARM_WEEKDAY_VALUE[rot_pkg::ALM_WEEKDAY_VALUE_HI:0];
        end
        else if (wr_en && reg_addr == rot_pkg::ADDR_ALARM0_WEEKDAY_VALUE)
        begin
            alarm_polarity <= reg_wdata[rot_pkg::ALM_POL];
            alarm0_match_mask <=
                reg_wdata[rot_pkg::ALM_MASK_HI:rot_pkg::ALM_MASK_LO];
            alarm0_weekday_value <= reg_wdata[rot_pkg::ALM_WEEKDAY_VALUE_HI:0];
        end
        else if (wr_en && reg_addr == rot_pkg::ADDR_ALARM1_WEEKDAY_VALUE)
        begin
            alarm1_match_mask <=
                reg_wdata[rot_pkg::ALM_MASK_HI:rot_pkg::ALM_MASK_LO];
            alarm1_weekday_value <= reg_wdata[rot_pkg::ALM_WEEKDAY_VALUE_HI:0];
        end
    end

    // alarm 0 flag: a hit wins over a software write in the same cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            alarm0_flag <= rot_pkg::RST_ALARM_WEEKDAY_VALUE[rot_pkg::ALM_FLAG];
        else if (alarm0_hit)
            alarm0_flag <= 1'b1;
        else if (wr_en && reg_addr == rot_pkg::ADDR_ALARM0_WEEKDAY_VALUE)
            alarm0_flag <= reg_wdata[rot_pkg::ALM_FLAG];
    end

    // alarm 1 flag: same set-wins behaviour
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            alarm1_flag <= rot_pkg::RST_ALARM_WEEKDAY_VALUE[rot_pkg::ALM_FLAG];
        else if (alarm1_hit)
            alarm1_flag <= 1'b1;
        else if (wr_en && reg_addr == rot_pkg::ADDR_ALARM1_WEEKDAY_VALUE)
            alarm1_flag <= reg_wdata[rot_pkg::ALM_FLAG];
    end

    // digital trim unit, kept running on backup power
    rot_trim #(
        .MINUTE_TICKS(MINUTE_TICKS)
    ) u_trim (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .osc_tick(osc_tick),
        .coarse_trim_mode(coarse_trim_mode),
        .trim_sign(trim_sign),
        .trim_magnitude(trim_magnitude),
        .trim_tick(trim_tick_int)
    );

    // square wave prescaler counts trimmed ticks
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            prescale <= '0;
        else if (trim_tick_int)
            prescale <= prescale + rot_pkg::PS_W'(1);
    end

    // square wave level; 1:1 is the untrimmed oscillator
    always_comb
    begin
        sqw_level = osc_level;
        if (coarse_trim_mode)
            sqw_level = prescale[rot_pkg::PS_TAP_COARSE];
        else
        begin
            unique case (rot_pkg::rot_rate_type'(square_wave_rate_select))
                rot_pkg::RATE_1_1: sqw_level = osc_level;
                rot_pkg::RATE_1_4: sqw_level = prescale[rot_pkg::PS_TAP_DIV4];
                rot_pkg::RATE_1_8: sqw_level = prescale[rot_pkg::PS_TAP_DIV8];
                rot_pkg::RATE_1_32768:
                    sqw_level = prescale[rot_pkg::PS_TAP_DIV32768];
            endcase
        end
    end

    // alarm output level from flags, enables and polarity
    always_comb
    begin
        alarm_level = 1'b1;
        if (alarm0_enable && alarm1_enable)
            alarm_level = alarm_polarity ? (alarm0_flag || alarm1_flag)
                : !(alarm0_flag && alarm1_flag);
        else if (alarm0_enable)
            alarm_level = alarm_polarity ? alarm0_flag
                : !alarm0_flag;
        else if (alarm1_enable)
            alarm_level = alarm_polarity ? alarm1_flag
                : !alarm1_flag;
    end

    // pin source priority; backup drops square wave and general output
    always_comb
    begin
        next_pin_level = 1'b1;
        if (square_wave_enable && !on_backup)
            next_pin_level = sqw_level;
        else if (alarm0_enable || alarm1_enable)
            next_pin_level = alarm_level;
        else if (!on_backup)
            next_pin_level = pin_level;
        else
            next_pin_level = 1'b1; // released
        next_pin_drive = !next_pin_level;
    end

    // open-drain pin: pull low when the level is 0, else release
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            multi_function_pin_o <= 1'b0;
            multi_function_pin_oe <= 1'b0;
        end
        else
        begin
            multi_function_pin_o <= 1'b0;
            multi_function_pin_oe <= next_pin_drive;
        end
    end

    // read data mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            rot_pkg::ADDR_CONTROL:
                next_rdata = {pin_level, square_wave_enable, alarm1_enable,
                    alarm0_enable, ext_clk_bit, coarse_trim_mode,
                    square_wave_rate_select};
            rot_pkg::ADDR_OSC_TRIM:
                next_rdata = {trim_sign, trim_magnitude};
            rot_pkg::ADDR_ALARM0_WEEKDAY_VALUE:
                next_rdata = {alarm_polarity, alarm0_match_mask, alarm0_flag,
                    alarm0_weekday_value};
            rot_pkg::ADDR_ALARM1_WEEKDAY_VALUE:
                next_rdata = {alarm_polarity, alarm1_match_mask, alarm1_flag,
                    alarm1_weekday_value};
            default:
                next_rdata = 8'h00;
        endcase
    end

    // registered read data, updated on each read strobe
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // registered status outputs
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trim_tick <= 1'b0;
            external_clock_input <= 1'b0;
        end
        else
        begin
            trim_tick <= trim_tick_int;
            external_clock_input <= ext_clk_bit;
        end
    end

endmodule : rot_top

// file: tb/rot_osc_model.sv
// oscillator source and pin pull-up standing outside the block
// assumes core_clk at 100 MHz; one oscillator period is PERIOD cycles
`timescale 1ns/1ps
module rot_osc_model #(
    parameter int PERIOD = 8
)(
    // clock
    input wire logic core_clk,
    // oscillator outputs
    output logic osc_tick,
    output logic osc_level,
    // open-drain pin
    input wire logic pin_oe,
    output logic pin_level
);
    int phase = 0;

    // start quiet
    initial
    begin
        osc_tick = 1'b0;
        osc_level = 1'b0;
    end

    // free-running oscillator, changed on the falling edge only
    always @(negedge core_clk)
    begin
        phase <= (phase + 1) % PERIOD;
        osc_tick <= (phase == 0); // single-cycle pulse, never back to back
        osc_level <= (phase < PERIOD / 2);
    end

    // pull-up: the wire is high unless the block pulls it low
    assign pin_level = pin_oe ? 1'b0 : 1'b1;
endmodule : rot_osc_model

// file: tb/rot_top_chk.sv
// assertions on pin levels, register writes and trimmed ticks
// assumes it is bound to rot_top and sees only its ports
`timescale 1ns/1ps
module rot_top_chk #(
    parameter int unsigned MINUTE_TICKS = rot_pkg::MINUTE_TICKS
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // oscillator, alarms and supply
    input wire logic osc_tick,
    input wire logic alarm0_hit,
    input wire logic on_backup,
    // outputs under watch
    input wire logic multi_function_pin_oe,
    input wire logic trim_tick,
    input wire logic external_clock_input,
    input wire logic alarm0_flag,
    input wire logic alarm1_flag
);
    logic [7:0] ctl;
    logic [7:0] trim;
    logic pol;
    logic trim_used;
    logic wr_ok;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // writes land only while main power is present
    assign wr_ok = reg_wr && !on_backup;

    // shadow of control, trim and polarity
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl <= rot_pkg::RST_CONTROL;
            trim <= rot_pkg::RST_OSC_TRIM;
            pol <= 1'b0;
            trim_used <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (reg_addr == rot_pkg::ADDR_CONTROL)
                ctl <= reg_wdata;
            if (reg_addr == rot_pkg::ADDR_OSC_TRIM)
                trim <= reg_wdata;
            if (reg_addr == rot_pkg::ADDR_ALARM0_WEEKDAY_VALUE)
                pol <= reg_wdata[7];
            if (reg_addr == rot_pkg::ADDR_OSC_TRIM && reg_wdata[6:0] != 7'h00)
                trim_used <= 1'b1;
        end
    end

    gp_level_a: assert property (
        ctl[6:4] == 3'h0 && !on_backup
        |=> multi_function_pin_oe == !$past(ctl[7]))
        else $error("pin does not follow the level bit");
    gp_backup_a: assert property (
        ctl[6:4] == 3'h0 && on_backup |=> !multi_function_pin_oe)
        else $error("pin driven on backup supply");
    one_alarm0_a: assert property (
        ctl[6:4] == 3'h1
        |=> multi_function_pin_oe == $past(alarm0_flag ^ pol))
        else $error("single alarm0 pin level wrong");
    one_alarm1_a: assert property (
        ctl[6:4] == 3'h2
        |=> multi_function_pin_oe == $past(alarm1_flag ^ pol))
        else $error("single alarm1 pin level wrong");
    dual_alarm_a: assert property (
        ctl[6:4] == 3'h3 |=> multi_function_pin_oe == $past(pol ?
        !(alarm0_flag | alarm1_flag) : (alarm0_flag & alarm1_flag)))
        else $error("dual alarm pin level wrong");
    flag_set_a: assert property (
        alarm0_hit |=> alarm0_flag)
        else $error("alarm hit did not set the flag");
    ext_clk_a: assert property (
        wr_ok && reg_addr == rot_pkg::ADDR_CONTROL
        |-> ##2 external_clock_input == $past(reg_wdata[3], 2))
        else $error("clock input bit not taken");
    trim_read_a: assert property (
        reg_rd && reg_addr == rot_pkg::ADDR_OSC_TRIM
        |=> reg_rdata == $past(trim))
        else $error("trim register read wrong");
    tick_pass_a: assert property (
        !trim_used && osc_tick |-> ##2 trim_tick)
        else $error("untrimmed tick lost");
    tick_none_a: assert property (
        !trim_used && !osc_tick |-> ##2 !trim_tick)
        else $error("tick added while trim is off");
endmodule : rot_top_chk

bind rot_top rot_top_chk #(.MINUTE_TICKS(MINUTE_TICKS)) i_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .osc_tick(osc_tick),
    .alarm0_hit(alarm0_hit),
    .on_backup(on_backup),
    .multi_function_pin_oe(multi_function_pin_oe),
    .trim_tick(trim_tick),
    .external_clock_input(external_clock_input),
    .alarm0_flag(alarm0_flag),
    .alarm1_flag(alarm1_flag)
);

// file: tb/test_rtc_output_pin_and_digital_trim.sv
// self-checking bench for the output pin and trim block
// assumes rot_top with a 512-tick minute and the oscillator model
`timescale 1ns/1ps
module test_rtc_output_pin_and_digital_trim;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic alarm0_hit = 1'b0;
    logic alarm1_hit = 1'b0;
    logic on_backup = 1'b0;
    logic [7:0] reg_rdata;
    logic osc_tick, osc_level, pin_oe, pin_level, trim_tick;
    logic pin_o, ext_clk;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int osc_n = 0;
    int trim_n = 0;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    rot_top #(.MINUTE_TICKS(512)) i_dut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .osc_tick(osc_tick),
        .osc_level(osc_level),
        .alarm0_hit(alarm0_hit),
        .alarm1_hit(alarm1_hit),
        .on_backup(on_backup),
        .multi_function_pin_i(pin_level),
        .multi_function_pin_o(pin_o),
        .multi_function_pin_oe(pin_oe),
        .trim_tick(trim_tick),
        .external_clock_input(ext_clk),
        .alarm0_flag(),
        .alarm1_flag()
    );

    rot_osc_model i_osc (
        .core_clk(core_clk),
        .osc_tick(osc_tick),
        .osc_level(osc_level),
        .pin_oe(pin_oe),
        .pin_level(pin_level)
    );

    // tick counters and run limit
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        osc_n <= rst_b ? osc_n + int'(osc_tick) : 0;
        trim_n <= rst_b ? trim_n + int'(trim_tick) : 0;
        if (cycles == 80000)
        begin
            miscompares = miscompares + 1;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic do_reset();
        @(negedge core_clk);
        rst_b = 1'b0;
        on_backup = 1'b0;
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    task automatic pin_is(input logic exp);
        repeat (3) @(negedge core_clk);
        chk("pin_level", {15'h0, pin_level}, {15'h0, exp});
        chk("pin_o", {15'h0, pin_o}, 16'h0000);
    endtask : pin_is

    task automatic hit(input logic a, input logic b);
        @(negedge core_clk);
        alarm0_hit = a;
        alarm1_hit = b;
        @(negedge core_clk);
        alarm0_hit = 1'b0;
        alarm1_hit = 1'b0;
    endtask : hit

    // reset values, unmapped place and trim register
    task automatic t_regs();
        do_reset();
        rd(rot_pkg::ADDR_CONTROL, rot_pkg::RST_CONTROL);
        rd(rot_pkg::ADDR_OSC_TRIM, rot_pkg::RST_OSC_TRIM);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        wr(rot_pkg::ADDR_OSC_TRIM, 8'h85);
        rd(rot_pkg::ADDR_OSC_TRIM, 8'h85);
        wr(rot_pkg::ADDR_CONTROL, 8'h88);
        rd(rot_pkg::ADDR_CONTROL, 8'h88);
        chk("external_clock_input", {15'h0, ext_clk}, 16'h0001);
    endtask : t_regs

    // general-purpose level and backup release
    task automatic t_gp();
        do_reset();
        pin_is(1'b1);
        wr(rot_pkg::ADDR_CONTROL, 8'h00);
        pin_is(1'b0);
        on_backup = 1'b1;
        pin_is(1'b1);
        on_backup = 1'b0;
        pin_is(1'b0);
    endtask : t_gp

    // single and dual alarm levels, then square wave priority
    task automatic t_alarm();
        int n;
        wr(rot_pkg::ADDR_CONTROL, 8'h10);
        pin_is(1'b1);
        hit(1'b1, 1'b0);
        pin_is(1'b0);
        wr(rot_pkg::ADDR_ALARM0_WEEKDAY_VALUE, 8'h80);
        pin_is(1'b0);
        wr(rot_pkg::ADDR_CONTROL, 8'h20);
        hit(1'b0, 1'b1);
        pin_is(1'b1);
        wr(rot_pkg::ADDR_CONTROL, 8'h30);
        for (int i = 0; i < 8; i++)
        begin
            wr(rot_pkg::ADDR_ALARM0_WEEKDAY_VALUE, {i[2], 7'h00});
            wr(rot_pkg::ADDR_ALARM1_WEEKDAY_VALUE, 8'h00);
            hit(i[1], i[0]);
            pin_is(i[2] ? (i[1] | i[0]) : !(i[1] & i[0]));
        end
        wr(rot_pkg::ADDR_CONTROL, 8'h70);
        repeat (3) @(negedge core_clk);
        n = 0;
        repeat (80)
        begin
            @(negedge core_clk);
            n = n + int'(pin_level);
        end
        chk("pin_high_count", 16'(n), 16'd40);
    endtask : t_alarm

    // one minute period, or three coarse periods: surplus of trimmed over raw ticks at tick 900
    task automatic t_trim(input logic [7:0] d, input logic c,
                          input logic b, input int exp);
        do_reset();
        wr(rot_pkg::ADDR_CONTROL, {5'h10, c, 2'h0});
        wr(rot_pkg::ADDR_OSC_TRIM, d);
        on_backup = b;
        while (osc_n < 900)
            @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        chk("tick_surplus", 16'(trim_n - osc_n), 16'(exp));
    endtask : t_trim

    // host calibration: measure the 1:8 wave, derive trims, apply them
    task automatic t_cal();
        real f_meas;
        real ppm;
        int n;
        int mag;
        do_reset();
        wr(rot_pkg::ADDR_CONTROL, 8'h42);
        repeat (70) @(negedge core_clk);
        n = 0;
        repeat (640)
        begin
            @(negedge core_clk);
            n = n + int'(pin_level);
        end
        chk("pin_high_count", 16'(n), 16'd320);
        // slow oscillator: positive error clocks, sign set
        f_meas = 4096.0 - 3.0 / 240.0;
        mag = int'((4096.0 - f_meas) * 32768.0 / 4096.0 * 60.0 / 2.0);
        t_trim({1'b1, 7'(mag)}, 1'b0, 1'b0, 6);
        // clock gained time: fast oscillator, sign cleared
        ppm = 4.0 / 1966080.0 * 1000000.0;
        mag = int'(ppm * 32768.0 * 60.0 / 1000000.0 / 2.0);
        t_trim({1'b0, 7'(mag)}, 1'b0, 1'b0, -4);
    endtask : t_cal

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // main sequence
    initial
    begin
        t_regs();
        t_gp();
        t_alarm();
        t_trim(8'h83, 1'b0, 1'b0, 6);
        t_trim(8'h03, 1'b0, 1'b0, -6);
        t_trim(8'hff, 1'b0, 1'b0, 254);
        t_trim(8'h7f, 1'b0, 1'b0, -254);
        t_trim(8'h00, 1'b0, 1'b0, 0);
        t_trim(8'h81, 1'b0, 1'b1, 2);
        t_trim(8'h83, 1'b1, 1'b0, 18);
        t_cal();
        summarize();
    end
endmodule : test_rtc_output_pin_and_digital_trim
